// ==== common/tcs_pkg.sv ====
// Purpose: Shared constants and types for the terminal control pins
// Assumes: 4 ns system clock
// Notes: Register offsets are byte addresses on the Wishbone bus
package tcs_pkg;
    localparam int CLK_NS = 4;
    // Internal time-tag tick, longest period, rounded down
    localparam int TAG_TICK_NS = 2000;
    localparam int TAG_TICK_CYC = TAG_TICK_NS / CLK_NS;
    // Eeprom serial clock half period, least time, rounded up
    localparam int EE_HALF_NS = 20;
    localparam int EE_HALF_CYC = (EE_HALF_NS + CLK_NS - 1) / CLK_NS;
    // Cycles for strap synchronisers to settle before capture
    localparam int BOOT_CYC = 3;
    localparam logic [3:0] ADR_CFG = 4'h0;
    localparam logic [3:0] ADR_STAT = 4'h4;
    localparam logic [3:0] ADR_TAG = 4'h8;
    localparam logic [3:0] ADR_SWORD = 4'hc;
    localparam int CFG_START_BIT = 0;
    localparam int CFG_TSEL_LSB = 1;
    localparam logic [2:0] TSEL_EXT = 3'h1;
    localparam logic [2:0] TSEL_RST = 3'h0;
    localparam int STAT_READY_BIT = 0;
    localparam int STAT_ACTIVE_BIT = 1;
    localparam int STAT_SUBSYSTEM_FLAG_BIT = 2;
    localparam int STAT_FAIL_BIT = 3;
    localparam int SWORD_SUBSYSTEM_FLAG_BIT = 2;
    localparam logic [7:0] EE_READ_CMD = 8'h03;
    localparam int EE_HDR_BYTES = 3;
    localparam logic [15:0] RAM_PAT_KEY = 16'h5a3c;
    typedef enum logic [4:0] {
        ST_BOOT = 5'b00001,
        ST_RTEST = 5'b00010,
        ST_INIT = 5'b00100,
        ST_READY = 5'b01000,
        ST_HOLD = 5'b10000
    } tcs_state_t;
    function automatic logic [15:0] tcs_pat(input logic [15:0] a);
        return a ^ RAM_PAT_KEY;
    endfunction : tcs_pat
endpackage : tcs_pkg

// ==== verilog/tcs_spi_master.sv ====
// Purpose: One-byte SPI master, mode 0, for the init eeprom
// Assumes: i_miso already synchronised
// Notes: Chip select is driven by the caller
`timescale 1ns/10ps
module tcs_spi_master import tcs_pkg::*; #(
    parameter int HALF_CYC = EE_HALF_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_start,
    input wire logic [7:0] i_tx,
    input wire logic i_miso,
    output logic o_busy,
    output logic o_done,
    output logic [7:0] o_rx,
    output logic o_sclk,
    output logic o_mosi
);
    localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);
    logic busy_r, busy_nxt, done_r, done_nxt, sclk_r, sclk_nxt;
    logic mosi_r, mosi_nxt;
    logic [7:0] div_r, div_nxt, sh_r, sh_nxt, rx_r, rx_nxt;
    logic [2:0] cnt_r, cnt_nxt;

    always_comb begin
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        sclk_nxt = sclk_r;
        mosi_nxt = mosi_r;
        div_nxt = div_r;
        sh_nxt = sh_r;
        rx_nxt = rx_r;
        cnt_nxt = cnt_r;
        if (!busy_r) begin
            if (i_start) begin
                busy_nxt = 1'b1;
                sh_nxt = i_tx;
                mosi_nxt = i_tx[7];
                div_nxt = 8'h00;
                cnt_nxt = 3'h0;
            end
        end else if (div_r == HALF_M1) begin
            div_nxt = 8'h00;
            if (!sclk_r) begin
                sclk_nxt = 1'b1;
                rx_nxt = {rx_r[6:0], i_miso};
            end else begin
                sclk_nxt = 1'b0;
                if (cnt_r == 3'h7) begin
                    busy_nxt = 1'b0;
                    done_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + 3'h1;
                    sh_nxt = {sh_r[6:0], 1'b0};
                    mosi_nxt = sh_r[6];
                end
            end
        end else begin
            div_nxt = div_r + 8'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            sclk_r <= 1'b0;
            mosi_r <= 1'b0;
            div_r <= 8'h00;
            sh_r <= 8'h00;
            rx_r <= 8'h00;
            cnt_r <= 3'h0;
        end else begin
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            sclk_r <= sclk_nxt;
            mosi_r <= mosi_nxt;
            div_r <= div_nxt;
            sh_r <= sh_nxt;
            rx_r <= rx_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign o_busy = busy_r;
    assign o_done = done_r;
    assign o_rx = rx_r;
    assign o_sclk = sclk_r;
    assign o_mosi = mosi_r;

    property p_sclk_idle;
        @(posedge i_clk) disable iff (!i_rst_b)
        (!busy_r && !done_r) |-> !sclk_r;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle)
        else $error("Serial clock moves while idle");
endmodule : tcs_spi_master

// ==== verilog/tcs_ctrl_pins.sv ====
// Purpose: Ready, active, time-tag, subsystem and self-init control
// Assumes: Wishbone classic slave, straps sampled after reset release
// Notes: Loopback test is not modelled; test pin reruns the RAM test
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/10ps
// Contract
// - Ready stays low during self-initialization or built-in test.
// - Execution starts only after ready is high and start bit set.
// - Active high while processing valid command; falling edge ends message.
// - All logic runs from the master clock.
// - Select 001 counts tag clock pin rising edges; otherwise internal tick.
// - Subsystem fail input high sets subsystem flag in status word.
// - Device is SPI master to eeprom: select, clock, MOSI out, MISO in.
// - Test pin runs RAM self-test with ready held low.
// - Skip strap low at reset release tests whole RAM; high skips.
// - Auto-init strap high at reset release copies eeprom to RAM, except if test pin is high at end of RAM test.
module tcs_ctrl_pins import tcs_pkg::*; #(
    parameter int RAM_AW = 15,
    parameter int TAG_CYC = TAG_TICK_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    output logic o_ready,
    output logic o_active,
    input wire logic i_cmd_valid,
    input wire logic i_msg_done,
    input wire logic i_tag_clock_in,
    input wire logic i_subsystem_fail_in,
    output logic o_subsystem_flag,
    input wire logic i_test,
    input wire logic i_ram_test_skip,
    input wire logic i_auto_init_request,
    output logic o_eeprom_chip_select_n,
    output logic o_eeprom_serial_clock,
    output logic o_eeprom_mosi,
    input wire logic i_eeprom_miso
);
    localparam int DEPTH = 1 << RAM_AW;
    localparam int EBW = RAM_AW + 2;
    localparam logic [EBW-1:0] EB_LAST = EBW'(EE_HDR_BYTES + 2 * DEPTH - 1);
    localparam logic [EBW-1:0] EB_HDR = EBW'(EE_HDR_BYTES);
    localparam logic [RAM_AW-1:0] IDX_LAST = RAM_AW'(DEPTH - 1);
    localparam logic [15:0] TAG_M1 = 16'(TAG_CYC - 1);
    localparam logic [1:0] BOOT_M1 = 2'(BOOT_CYC - 1);

    logic [15:0] mem [DEPTH];
    // Pin synchronisers: tag, subsystem fail, test, skip, auto, miso
    logic [5:0] sy1_r, sy2_r;
    logic tag_d_r;
    tcs_state_t st_r, st_nxt;
    logic [1:0] boot_r, boot_nxt;
    logic pend_r, pend_nxt, phase_r, phase_nxt;
    logic fail_r, fail_nxt, wait_r, wait_nxt, cs_r, cs_nxt;
    logic [RAM_AW-1:0] idx_r, idx_nxt;
    logic [EBW-1:0] eb_r, eb_nxt, dsub;
    logic [7:0] hi_r, hi_nxt;
    logic ready_r, active_r, active_nxt, start_r, start_nxt;
    logic [2:0] tsel_r, tsel_nxt;
    logic [15:0] tag_r, tag_nxt, tdiv_r, tdiv_nxt, sword_r, sword_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic tag_s, sub_s, test_s, skip_s, auto_s, miso_s;
    logic wb_hit, int_tick, ext_edge, exec, spi_go;
    logic spi_busy, spi_done;
    logic [7:0] spi_rx;
    logic mem_we;
    logic [RAM_AW-1:0] mem_a;
    logic [15:0] mem_d;

    assign {miso_s, auto_s, skip_s, test_s, sub_s, tag_s} = sy2_r;
    assign wb_hit = i_wb_cyc && i_wb_stb && !ack_r;
    assign int_tick = (tdiv_r == TAG_M1);
    assign ext_edge = tag_s && !tag_d_r;
    assign exec = ready_r && start_r;
    assign spi_go = (st_r == ST_INIT) && !spi_busy && !wait_r;
    assign dsub = eb_r - EB_HDR;

    tcs_spi_master #(.HALF_CYC(EE_HALF_CYC)) u_spi (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_start(spi_go),
        .i_tx((eb_r == '0) ? EE_READ_CMD : 8'h00),
        .i_miso(miso_s),
        .o_busy(spi_busy),
        .o_done(spi_done),
        .o_rx(spi_rx),
        .o_sclk(o_eeprom_serial_clock),
        .o_mosi(o_eeprom_mosi)
    );

    // Sequencer: boot, RAM test, eeprom copy, ready, test hold
    always_comb begin
        st_nxt = st_r;
        boot_nxt = boot_r;
        pend_nxt = pend_r;
        phase_nxt = phase_r;
        fail_nxt = fail_r;
        idx_nxt = idx_r;
        eb_nxt = eb_r;
        hi_nxt = hi_r;
        wait_nxt = wait_r;
        cs_nxt = cs_r;
        mem_we = 1'b0;
        mem_a = idx_r;
        mem_d = tcs_pat(16'(idx_r));
        case (st_r)
            ST_BOOT: begin
                boot_nxt = boot_r + 2'h1;
                if (boot_r == BOOT_M1) begin
                    pend_nxt = auto_s;
                    if (!skip_s) begin
                        st_nxt = ST_RTEST;
                    end else if (auto_s) begin
                        st_nxt = ST_INIT;
                        cs_nxt = 1'b0;
                    end else begin
                        st_nxt = ST_READY;
                    end
                end
            end
            ST_RTEST: begin
                idx_nxt = idx_r + 1'b1;
                if (!phase_r) begin
                    mem_we = 1'b1;
                end else if (mem[idx_r] != tcs_pat(16'(idx_r))) begin
                    fail_nxt = 1'b1;
                end
                if (idx_r == IDX_LAST) begin
                    phase_nxt = !phase_r;
                    if (phase_r) begin
                        if (test_s) begin
                            st_nxt = ST_HOLD;
                        end else if (pend_r) begin
                            st_nxt = ST_INIT;
                            cs_nxt = 1'b0;
                        end else begin
                            st_nxt = ST_READY;
                        end
                    end
                end
            end
            ST_INIT: begin
                mem_a = dsub[RAM_AW:1];
                mem_d = {hi_r, spi_rx};
                if (spi_go) begin
                    wait_nxt = 1'b1;
                end
                if (spi_done) begin
                    wait_nxt = 1'b0;
                    eb_nxt = eb_r + 1'b1;
                    if (eb_r >= EB_HDR) begin
                        if (!dsub[0]) begin
                            hi_nxt = spi_rx;
                        end else begin
                            mem_we = 1'b1;
                        end
                    end
                    if (eb_r == EB_LAST) begin
                        cs_nxt = 1'b1;
                        pend_nxt = 1'b0;
                        eb_nxt = '0;
                        st_nxt = ST_READY;
                    end
                end
            end
            ST_READY: begin
                if (test_s) begin
                    st_nxt = ST_RTEST;
                    idx_nxt = '0;
                    phase_nxt = 1'b0;
                    fail_nxt = 1'b0;
                end
            end
            ST_HOLD: begin
                if (!test_s) begin
                    st_nxt = ST_READY;
                end
            end
            default: st_nxt = ST_BOOT;
        endcase
    end

    // Terminal control: active, time tag, status word, bus slave
    always_comb begin
        active_nxt = 1'b0;
        if (exec) begin
            active_nxt = active_r ? !i_msg_done : i_cmd_valid;
        end
        tdiv_nxt = int_tick ? 16'h0000 : tdiv_r + 16'h0001;
        tag_nxt = tag_r;
        if ((tsel_r == TSEL_EXT) ? ext_edge : int_tick) begin
            tag_nxt = tag_r + 16'h0001;
        end
        sword_nxt = 16'h0000;
        sword_nxt[SWORD_SUBSYSTEM_FLAG_BIT] = sub_s;
        start_nxt = start_r;
        tsel_nxt = tsel_r;
        if (st_r == ST_INIT && mem_we && mem_a == '0) begin
            tsel_nxt = mem_d[CFG_TSEL_LSB +: 3];
        end
        ack_nxt = wb_hit;
        dat_nxt = 32'h0000_0000;
        if (wb_hit) begin
            case (i_wb_adr)
                ADR_CFG: begin
                    dat_nxt[CFG_START_BIT] = start_r;
                    dat_nxt[CFG_TSEL_LSB +: 3] = tsel_r;
                    if (i_wb_we && i_wb_sel[0]) begin
                        start_nxt = i_wb_dat[CFG_START_BIT];
                        tsel_nxt = i_wb_dat[CFG_TSEL_LSB +: 3];
                    end
                end
                ADR_STAT: begin
                    dat_nxt[STAT_READY_BIT] = ready_r;
                    dat_nxt[STAT_ACTIVE_BIT] = active_r;
                    dat_nxt[STAT_SUBSYSTEM_FLAG_BIT] = sword_r[SWORD_SUBSYSTEM_FLAG_BIT];
                    dat_nxt[STAT_FAIL_BIT] = fail_r;
                end
                ADR_TAG: dat_nxt[15:0] = tag_r;
                ADR_SWORD: dat_nxt[15:0] = sword_r;
                default: dat_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sy1_r <= 6'h00;
            sy2_r <= 6'h00;
            tag_d_r <= 1'b0;
            st_r <= ST_BOOT;
            boot_r <= 2'h0;
            pend_r <= 1'b0;
            phase_r <= 1'b0;
            fail_r <= 1'b0;
            idx_r <= '0;
            eb_r <= '0;
            hi_r <= 8'h00;
            wait_r <= 1'b0;
            cs_r <= 1'b1;
            ready_r <= 1'b0;
            active_r <= 1'b0;
            start_r <= 1'b0;
            tsel_r <= TSEL_RST;
            tag_r <= 16'h0000;
            tdiv_r <= 16'h0000;
            sword_r <= 16'h0000;
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            sy1_r <= {i_eeprom_miso, i_auto_init_request, i_ram_test_skip,
                      i_test, i_subsystem_fail_in, i_tag_clock_in};
            sy2_r <= sy1_r;
            tag_d_r <= tag_s;
            st_r <= st_nxt;
            boot_r <= boot_nxt;
            pend_r <= pend_nxt;
            phase_r <= phase_nxt;
            fail_r <= fail_nxt;
            idx_r <= idx_nxt;
            eb_r <= eb_nxt;
            hi_r <= hi_nxt;
            wait_r <= wait_nxt;
            cs_r <= cs_nxt;
            ready_r <= (st_nxt == ST_READY);
            active_r <= active_nxt;
            start_r <= start_nxt;
            tsel_r <= tsel_nxt;
            tag_r <= tag_nxt;
            tdiv_r <= tdiv_nxt;
            sword_r <= sword_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    always_ff @(posedge i_clk) begin
        if (mem_we) begin
            mem[mem_a] <= mem_d;
        end
    end

    assign o_ready = ready_r;
    assign o_active = active_r;
    assign o_subsystem_flag = sword_r[SWORD_SUBSYSTEM_FLAG_BIT];
    assign o_eeprom_chip_select_n = cs_r;
    assign o_wb_ack = ack_r;
    assign o_wb_dat = dat_r;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_boot_end;
        st_r == ST_BOOT && boot_r == BOOT_M1;
    endsequence
    property p_ready_low;
        (st_r != ST_READY) |-> !o_ready;
    endproperty
    a_ready_low: assert property (p_ready_low)
        else $error("Ready high during init or test");
    property p_exec;
        $rose(o_active) |-> $past(ready_r && start_r && i_cmd_valid);
    endproperty
    a_exec: assert property (p_exec)
        else $error("Active without ready, start bit or command");
    property p_active_end;
        $fell(o_active) |-> $past(i_msg_done) || $past(!exec);
    endproperty
    a_active_end: assert property (p_active_end)
        else $error("Active fell without message end");
    property p_tick;
        int_tick |=> !int_tick [*8];
    endproperty
    a_tick: assert property (p_tick)
        else $error("Internal tag tick period too short");
    property p_tag_src;
        (tsel_r != TSEL_EXT && !int_tick) |=> $stable(tag_r);
    endproperty
    a_tag_src: assert property (p_tag_src)
        else $error("Tag moved without internal tick");
    property p_subsystem_flag;
        i_subsystem_fail_in |-> ##3 o_subsystem_flag;
    endproperty
    a_subsystem_flag: assert property (p_subsystem_flag)
        else $error("Subsystem flag not set");
    property p_cs_sclk;
        o_eeprom_chip_select_n |-> !o_eeprom_serial_clock;
    endproperty
    a_cs_sclk: assert property (p_cs_sclk)
        else $error("Serial clock moves without select");
    property p_test;
        (st_r == ST_READY && test_s) |=> st_r == ST_RTEST ##1 !o_ready;
    endproperty
    a_test: assert property (p_test)
        else $error("Test pin did not start RAM test");
    property p_skip;
        s_boot_end ##0 !skip_s |=> st_r == ST_RTEST;
    endproperty
    a_skip: assert property (p_skip)
        else $error("RAM test not run at reset");
    property p_auto;
        s_boot_end ##0 (skip_s && auto_s) |=> st_r == ST_INIT ##1
            !o_eeprom_chip_select_n;
    endproperty
    a_auto: assert property (p_auto)
        else $error("Auto init not started");
    property p_ready_rise;
        $rose(o_ready) |-> !pend_r && o_eeprom_chip_select_n;
    endproperty
    a_ready_rise: assert property (p_ready_rise)
        else $error("Ready rose with init pending");
endmodule : tcs_ctrl_pins

// ==== bench/tcs_ee_model.sv ====
// Purpose: Serial eeprom slave model for the self-init port
// Assumes: SPI mode 0, MSB first, idle-low serial clock
// Notes: Data byte k after the header is {k[3:0], 4'h2}
`timescale 1ns/10ps
module tcs_ee_model (
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_mosi,
    output logic o_miso
);
    int nb;
    int bad;
    logic [7:0] sr;
    logic [7:0] hdr [3];
    logic [7:0] db;
    logic miso_r;
    initial begin
        nb = 0;
        bad = 0;
        miso_r = 1'b0;
    end
    // Bit count restarts with each frame
    always @(negedge i_cs_n) begin
        nb = 0;
        miso_r = 1'b0;
    end
    // Slave captures on rising clock
    always @(posedge i_sclk) begin
        if (!i_cs_n) begin
            sr = {sr[6:0], i_mosi};
            if (nb >= 24 && i_mosi !== 1'b0) bad++;
            nb++;
            if (nb % 8 == 0 && nb <= 24) hdr[nb / 8 - 1] = sr;
        end
    end
    // Shift out on falling clock, data only after the header
    always @(negedge i_sclk) begin
        if (!i_cs_n) begin
            db = 8'(nb / 8 - 3);
            db = {db[3:0], 4'h2};
            miso_r = (nb >= 24) ? db[7 - nb % 8] : 1'b0;
        end
    end
    // Deselected line falls to its pull-down
    assign o_miso = i_cs_n ? 1'b0 : miso_r;
endmodule : tcs_ee_model

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench for the terminal control pins
// Assumes: Wishbone classic master, eeprom model on the init port
// Notes: RAM_AW 4 and TAG_CYC 10 keep RAM test, eeprom copy and tag counts short
`timescale 1ns/10ps
module tb_top import tcs_pkg::*;;
    localparam int RT = 2 * (2 ** 4);
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, ready, active, sflag, cs_n, sclk, mosi, miso;
    logic cmdv = 1'b0;
    logic mdone = 1'b0;
    logic tclk = 1'b0;
    logic sfail = 1'b0;
    logic test = 1'b0;
    logic skip = 1'b0;
    logic autoi = 1'b1;
    logic [31:0] q, t0;
    int fails = 0;
    int comparisons = 0;
    int cyc_n = 0;
    int cs_falls = 0;
    int n;

    tcs_ctrl_pins #(.RAM_AW(4), .TAG_CYC(10)) u_tcs_ctrl_pins (
        .i_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .o_ready(ready),
        .o_active(active), .i_cmd_valid(cmdv), .i_msg_done(mdone),
        .i_tag_clock_in(tclk), .i_subsystem_fail_in(sfail),
        .o_subsystem_flag(sflag), .i_test(test),
        .i_ram_test_skip(skip), .i_auto_init_request(autoi),
        .o_eeprom_chip_select_n(cs_n), .o_eeprom_serial_clock(sclk),
        .o_eeprom_mosi(mosi), .i_eeprom_miso(miso));
    tcs_ee_model u_tcs_ee_model (
        .i_cs_n(cs_n), .i_sclk(sclk), .i_mosi(mosi), .o_miso(miso));

    always #2 clk = ~clk;

    task complete_run;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 30000) begin
            fails++;
            complete_run();
        end
    end
    always @(posedge clk) begin
        if (cs_n === 1'b0) chk("ready_in_copy", ready, 0);
    end
    always @(negedge cs_n) cs_falls++;

    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task pulse(input logic c);
        @(posedge clk);
        if (c) cmdv <= 1'b1;
        else mdone <= 1'b1;
        @(posedge clk);
        cmdv <= 1'b0;
        mdone <= 1'b0;
    endtask : pulse

    // Host waits for ready before any access
    task wait_rdy;
        n = 0;
        while (ready !== 1'b1 && n < 9000) begin
            @(posedge clk);
            n++;
        end
        chk("ready_up", ready, 1);
    endtask : wait_rdy

    task do_reset(input logic sk, input logic au);
        @(posedge clk);
        rst_b <= 1'b0;
        skip <= sk;
        autoi <= au;
        repeat (5) @(posedge clk);
        chk("reset_outs", {ready, active, cs_n, sclk}, 4'h2);
        rst_b <= 1'b1;
        wait_rdy();
    endtask : do_reset

    initial begin
        do_reset(1'b0, 1'b1);
        chk("copy_frames", cs_falls, 1);
        for (int i = 0; i < EE_HDR_BYTES; i++) begin
            chk("ee_header", u_tcs_ee_model.hdr[i], i ? 0 : EE_READ_CMD);
        end
        chk("ee_mosi_data", u_tcs_ee_model.bad, 0);
        chk("copy_bits", u_tcs_ee_model.nb, (EE_HDR_BYTES + RT) * 8);
        wb(1'b0, ADR_CFG, 0);
        chk("cfg_loaded", q[3:0], 4'h2);
        pulse(1'b1);
        repeat (3) begin
            @(posedge clk);
            chk("active_no_start", active, 0);
        end
        wb(1'b1, ADR_CFG, 32'h3);
        pulse(1'b1);
        @(posedge clk);
        chk("active_rise", active, 1);
        repeat (4) @(posedge clk);
        chk("active_hold", active, 1);
        wb(1'b0, ADR_STAT, 0);
        chk("stat_busy", q[1:0], 2'h3);
        pulse(1'b0);
        @(posedge clk);
        chk("active_fall", active, 0);
        wb(1'b0, ADR_TAG, 0);
        t0 = q;
        repeat (5) begin
            @(posedge clk);
            tclk <= 1'b1;
            repeat (4) @(posedge clk);
            tclk <= 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        wb(1'b0, ADR_TAG, 0);
        chk("tag_ext", 16'(q[15:0] - t0[15:0]), 5);
        wb(1'b1, ADR_CFG, 32'h1);
        wb(1'b0, ADR_TAG, 0);
        t0 = q;
        repeat (50) begin
            @(posedge clk);
            tclk <= ~tclk;
            @(posedge clk);
        end
        wb(1'b0, ADR_TAG, 0);
        n = int'(16'(q[15:0] - t0[15:0]));
        chk("tag_int", n >= 9 && n <= 12, 1);
        @(posedge clk);
        sfail <= 1'b1;
        repeat (4) @(posedge clk);
        chk("subsystem_flag_pin", sflag, 1);
        wb(1'b0, ADR_SWORD, 0);
        chk("sword_set", q[SWORD_SUBSYSTEM_FLAG_BIT], 1);
        sfail <= 1'b0;
        repeat (4) @(posedge clk);
        wb(1'b0, ADR_SWORD, 0);
        chk("sword_clear", q[SWORD_SUBSYSTEM_FLAG_BIT], 0);
        pulse(1'b1);
        @(posedge clk);
        chk("active_again", active, 1);
        test <= 1'b1;
        n = 0;
        while (ready !== 1'b0 && n < 10) begin
            @(posedge clk);
            n++;
        end
        chk("test_ready_low", n < 10, 1);
        repeat (2) @(posedge clk);
        chk("active_drop", active, 0);
        repeat (RT + 40) @(posedge clk);
        chk("test_pin_hold", ready, 0);
        test <= 1'b0;
        wait_rdy();
        wb(1'b0, ADR_STAT, 0);
        chk("stat_test_ok", q[STAT_FAIL_BIT], 0);
        wb(1'b0, 4'h2, 0);
        chk("unmapped_rd", q, 0);
        wb(1'b1, 4'h6, 32'hffffffff);
        wb(1'b0, ADR_CFG, 0);
        chk("cfg_kept", q[3:0], 4'h1);
        do_reset(1'b1, 1'b0);
        chk("skip_fast", n < RT, 1);
        chk("no_copy", cs_falls, 1);
        wb(1'b0, ADR_CFG, 0);
        chk("cfg_reset", q[3:0], 4'h0);
        do_reset(1'b0, 1'b0);
        chk("full_test", n >= RT, 1);
        do_reset(1'b1, 1'b1);
        chk("copy_no_test", cs_falls, 2);
        chk("copy_bits2", u_tcs_ee_model.nb, (EE_HDR_BYTES + RT) * 8);
        wb(1'b0, ADR_CFG, 0);
        chk("cfg_reloaded", q[3:0], 4'h2);
        complete_run();
    end
endmodule : tb_top
